//--- three_width_data_buffer.sv
// Data buffer end: read latches, lane steering, word swap and control port
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`include "buf_cfg.svh"
// How it works
// R1 - Latch strobes capture bus; output enable presents
// R2 - Writes pass lanes by direction and enables
// R3 - Controller asserts swap for 32-to-8 writes
// R4 - DMA, direction low: system to processor lanes
// R5 - DMA, direction high: processor to system lanes
// R6 - Controller asserts swap for 8-bit DMA
// R7 - One control port decoded at 61H
// R8 - Port bit 7 enables NMI output for parity status only
// R9 - Channel check or parity low sets bit 6
// R10 - Hit timer rising edge forces NMI, bit 7
// R11 - Write bit 3 clears hit status
// R12 - Write bit 2 clears parity status
// R13 - Bit 0 timer gate, bit 1 speaker
// R14 - Read bits 7,6 show hit, parity
// R15 - Read bits 5,4 timer output, refresh
// R16 - Read bits 3..0 return written values
// R17 - Status flags stay set until cleared
// R18 - Port over peripheral bus, steered to processor
module three_width_data_buffer
    import buf_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    buf_link_if.buffer link,
    input wire logic [31:0] cpuDataIn,
    output logic [31:0] cpuDataOut,
    output logic [3:0] cpuDataOe,
    input wire logic [15:0] sysDataIn,
    output logic [15:0] sysDataOut,
    output logic [1:0] sysDataOe,
    input wire logic channelCheckN,
    input wire logic parityN,
    input wire logic hitTimerInN,
    input wire logic refreshDetect,
    input wire logic timer2Out,
    output logic timer2Gate,
    output logic speakerEnable
);
    ////////////////////////////////////////////////////////////////////////////
    // Lane helpers

    // System byte feeding a processor lane; swap folds all lanes onto the low byte
    function automatic logic [7:0] sysByte(
        input logic [15:0] sys,
        input logic [1:0] lane,
        input logic swp
    );
        logic [7:0] b;
        b = sys[15:8];
        if (swp || !lane[0]) begin
            b = sys[7:0];
        end
        return b;
    endfunction

    // All four processor lanes as the system bus would fill them
    function automatic logic [3:0][7:0] sysWord(
        input logic [15:0] sys,
        input logic swp
    );
        logic [3:0][7:0] w;
        w = '0;
        for (int i = 0; i < 4; i++) begin
            w[i] = sysByte(sys, 2'(i), swp);
        end
        return w;
    endfunction

    // System half a processor lane lands on
    function automatic logic sysHalf(
        input logic [1:0] lane,
        input logic swp
    );
        logic h;
        h = lane[0];
        if (swp) begin
            h = 1'b0;
        end
        return h;
    endfunction

    // Byte-lane enables are active low
    function automatic logic laneOn(
        input logic [3:0] benN,
        input logic [1:0] lane
    );
        return !benN[lane];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    bufState_s s_r;
    bufState_s s_nxt;
    logic swapActive;
    logic portHit;
    logic portRead;
    logic portWrite;
    logic [7:0] portValue;
    logic [1:0] portLane;
    logic nmiLevel;
    logic [3:0][7:0] sysLanes;

    // Swap needs both controls; either one alone leaves the lanes straight
    assign swapActive = link.swapGate && link.swapDirection; // R3 R6
    assign sysLanes = sysWord(sysDataIn, swapActive); // R1 R4
    // Full address compare, so the port never shadows its neighbours
    assign portHit = (link.ioAddr == `PORT_ADDR); // R7
    assign portRead = portHit && link.ioRead;
    assign portWrite = portHit && link.ioWrite;
    assign portLane = link.ioAddr[1:0];

    ////////////////////////////////////////////////////////////////////////////
    // Control port

    // Port writes take the byte straight off the peripheral bus
    control_port i_control_port (
        .core_clk(core_clk),
        .rst(rst),
        .wrEn(portWrite), // R18
        .wrData(link.periphWrData),
        .channelCheckN(channelCheckN),
        .parityN(parityN),
        .hitTimerInN(hitTimerInN),
        .refreshDetect(refreshDetect),
        .timer2Out(timer2Out),
        .readValue(portValue),
        .timer2Gate(timer2Gate),
        .speakerEnable(speakerEnable),
        .nmi(nmiLevel)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Data paths

    always_comb begin
        s_nxt = s_r;
        // Read latches load while their strobe is high
        for (int i = 0; i < 4; i++) begin
            if (link.latchStrobes[i]) begin
                s_nxt.latch[i] = sysLanes[i]; // R1
            end
        end

        // Processor side: latch output has priority over a DMA pass
        s_nxt.cpuOe = '0;
        if (!link.sysDataOutEnableN) begin
            s_nxt.cpuOe = 4'hF; // R1
            for (int i = 0; i < 4; i++) begin
                s_nxt.cpuOut[i*8 +: 8] = s_r.latch[i]; // R1
            end
        end else if (!link.readDirectionN) begin
            for (int i = 0; i < 4; i++) begin
                if (laneOn(link.byteLaneEnablesN, 2'(i))) begin
                    s_nxt.cpuOe[i] = 1'b1; // R4
                    s_nxt.cpuOut[i*8 +: 8] = sysLanes[i]; // R4
                end
            end
        end
        // Port read lands on the lane its address selects
        if (portRead) begin
            s_nxt.cpuOe[portLane] = 1'b1; // R18
            s_nxt.cpuOut[portLane*8 +: 8] = portValue; // R18
        end

        // System side; with two lanes on one half the higher lane wins
        s_nxt.sysOe = '0;
        if (link.readDirectionN) begin
            for (int i = 0; i < 4; i++) begin
                if (laneOn(link.byteLaneEnablesN, 2'(i))) begin
                    if (sysHalf(2'(i), swapActive)) begin
                        s_nxt.sysOe[1] = 1'b1; // R2 R5
                        s_nxt.sysOut[15:8] = cpuDataIn[i*8 +: 8]; // R2 R5
                    end else begin
                        s_nxt.sysOe[0] = 1'b1; // R2 R5
                        s_nxt.sysOut[7:0] = cpuDataIn[i*8 +: 8]; // R2 R5
                    end
                end
            end
        end

        // Held until the next port read, so the controller may fetch it late
        if (portRead) begin
            s_nxt.rdData = portValue; // R14 R15 R16
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            // Out of reset neither bus is driven
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign cpuDataOut = s_r.cpuOut;
    assign cpuDataOe = s_r.cpuOe;
    assign sysDataOut = s_r.sysOut;
    assign sysDataOe = s_r.sysOe;
    assign link.periphRdData = s_r.rdData;
    assign link.nmi = nmiLevel; // R8
endmodule // three_width_data_buffer

//--- buf_cfg.svh
// Constants of the data buffer, its control port and the controller registers
`ifndef BUF_CFG_SVH
`define BUF_CFG_SVH

////////////////////////////////////////////////////////////////////////////////
// System control port
`define PORT_ADDR 16'h0061
`define PORT_ADDR_W 16
`define PW_TIMER_GATE 0
`define PW_SPEAKER 1
`define PW_CLR_PARITY 2
`define PW_CLR_HIT 3
`define PW_NMI_EN 7
`define PR_REFRESH 4
`define PR_TIMER_OUT 5
`define PR_PARITY 6
`define PR_HIT 7
`define PORT_CTL_W 4

////////////////////////////////////////////////////////////////////////////////
// Controller registers, byte offsets on AHB-Lite
`define R_STROBES 8'h00
`define R_IO_CMD 8'h04
`define R_IO_DATA 8'h08
`define R_IRQ_STATUS 8'h0C
`define R_IRQ_CLEAR 8'h10
`define R_IRQ_ENABLE 8'h14
`define STROBES_RST 32'h0000_0F30
`define ST_LATCH_LSB 0
`define ST_SYSTEM_DATA_OUT_ENABLE_N_N 4
`define ST_DIR_N 5
`define ST_BEN_LSB 8
`define ST_SWAP_GATE 12
`define ST_SWAP_DIR 13
`define CMD_DATA_LSB 16
`define CMD_READ 24
`define IOD_BUSY 8
`define IOD_NMI 9
`define EV_IO_DONE 0
`define EV_NMI 1
`define EV_W 2

`endif

//--- buf_pkg.sv
// Types shared by the data buffer and its controller
package buf_pkg;
    `include "buf_cfg.svh"

    typedef enum logic [1:0] {
        CTL_IDLE = 2'b00,
        CTL_STROBE = 2'b01,
        CTL_CAPTURE = 2'b10,
        CTL_SPARE = 2'b11
    } ctlState_e;

    typedef struct packed {
        logic [`PORT_CTL_W-1:0] ctl;
        logic nmiEn;
        logic hitFlag;
        logic parityFlag;
        logic hitPrev;
        logic timerGate;
        logic speakerEn;
    } portState_s;

    typedef struct packed {
        logic [3:0][7:0] latch;
        logic [31:0] cpuOut;
        logic [3:0] cpuOe;
        logic [15:0] sysOut;
        logic [1:0] sysOe;
        logic [7:0] rdData;
    } bufState_s;

    typedef struct packed {
        ctlState_e state;
        logic wrPend;
        logic [7:0] addrPh;
        logic [31:0] strobes;
        logic [31:0] cmd;
        logic cmdGo;
        logic ioRead;
        logic ioWrite;
        logic [7:0] ioData;
        logic [`EV_W-1:0] status;
        logic [`EV_W-1:0] enable;
        logic nmiPrev;
    } hostState_s;
endpackage

//--- buf_link_if.sv
// Strobes, port access and NMI between bus controller and data buffer
interface buf_link_if;
    logic [3:0] latchStrobes;
    logic sysDataOutEnableN;
    logic readDirectionN;
    logic [3:0] byteLaneEnablesN;
    logic swapGate;
    logic swapDirection;
    logic [15:0] ioAddr;
    logic ioRead;
    logic ioWrite;
    logic [7:0] periphWrData;
    logic [7:0] periphRdData;
    logic nmi;

    modport buffer (
        input latchStrobes, sysDataOutEnableN, readDirectionN, byteLaneEnablesN,
        input swapGate, swapDirection, ioAddr, ioRead, ioWrite, periphWrData,
        output periphRdData, nmi
    );

    modport controller (
        output latchStrobes, sysDataOutEnableN, readDirectionN, byteLaneEnablesN,
        output swapGate, swapDirection, ioAddr, ioRead, ioWrite, periphWrData,
        input periphRdData, nmi
    );
endinterface

//--- control_port.sv
// System control port: timer gate, speaker, sticky error flags and NMI
`include "buf_cfg.svh"
module control_port
    import buf_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic wrEn,
    input wire logic [7:0] wrData,
    input wire logic channelCheckN,
    input wire logic parityN,
    input wire logic hitTimerInN,
    input wire logic refreshDetect,
    input wire logic timer2Out,
    output logic [7:0] readValue,
    output logic timer2Gate,
    output logic speakerEnable,
    output logic nmi
);
    portState_s s_r;
    portState_s s_nxt;
    logic hitEdge;
    logic parityErr;

    always_comb begin
        s_nxt = s_r;
        hitEdge = hitTimerInN && !s_r.hitPrev; // R10
        parityErr = !channelCheckN || !parityN; // R9
        s_nxt.hitPrev = hitTimerInN;
        if (wrEn) begin
            s_nxt.ctl = wrData[`PORT_CTL_W-1:0]; // R16
            s_nxt.nmiEn = wrData[`PW_NMI_EN]; // R8
            s_nxt.timerGate = wrData[`PW_TIMER_GATE]; // R13
            s_nxt.speakerEn = wrData[`PW_SPEAKER]; // R13
            if (wrData[`PW_CLR_HIT]) begin
                s_nxt.hitFlag = 1'b0; // R11
            end
            if (wrData[`PW_CLR_PARITY]) begin
                s_nxt.parityFlag = 1'b0; // R12
            end
        end
        // Set after clear so an event in the clearing cycle survives
        if (hitEdge) begin
            s_nxt.hitFlag = 1'b1; // R17
        end
        if (parityErr) begin
            s_nxt.parityFlag = 1'b1; // R17
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
            s_r.hitPrev <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign readValue = {s_r.hitFlag, s_r.parityFlag, timer2Out, refreshDetect, s_r.ctl}; // R14 R15
    assign timer2Gate = s_r.timerGate;
    assign speakerEnable = s_r.speakerEn;
    // Hit timer forces NMI regardless of the enable
    assign nmi = s_r.hitFlag || (s_r.nmiEn && s_r.parityFlag); // R8 R10
endmodule // control_port

//--- buffer_controller.sv
// Controller end: AHB-Lite registers drive buffer strobes and port cycles
`include "buf_cfg.svh"
module buffer_controller
    import buf_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic irq,
    buf_link_if.controller link
);
    hostState_s s_r;
    hostState_s s_nxt;
    logic [`EV_W-1:0] events;
    logic [`EV_W-1:0] clearMask;

    ////////////////////////////////////////////////////////////////////////////
    // Bus, port sequencer and events

    always_comb begin
        s_nxt = s_r;
        clearMask = '0;
        s_nxt.wrPend = hsel && htrans[1] && hready && hwrite;
        if (hsel && htrans[1] && hready) begin
            s_nxt.addrPh = haddr[7:0];
        end
        if (s_r.wrPend) begin
            case (s_r.addrPh)
                `R_STROBES: s_nxt.strobes = hwdata;
                `R_IO_CMD: begin
                    // A command while busy is dropped
                    if (s_r.state == CTL_IDLE) begin
                        s_nxt.cmd = hwdata;
                        s_nxt.cmdGo = 1'b1;
                    end
                end
                `R_IRQ_CLEAR: clearMask = hwdata[`EV_W-1:0];
                `R_IRQ_ENABLE: s_nxt.enable = hwdata[`EV_W-1:0];
                default: ;
            endcase
        end

        events = '0;
        s_nxt.ioRead = 1'b0;
        s_nxt.ioWrite = 1'b0;
        case (s_r.state)
            CTL_IDLE: begin
                if (s_r.cmdGo) begin
                    s_nxt.cmdGo = 1'b0;
                    s_nxt.ioRead = s_r.cmd[`CMD_READ];
                    s_nxt.ioWrite = !s_r.cmd[`CMD_READ];
                    s_nxt.state = CTL_STROBE;
                end
            end
            CTL_STROBE: begin
                if (s_r.ioRead) begin
                    s_nxt.state = CTL_CAPTURE;
                end else begin
                    events[`EV_IO_DONE] = 1'b1;
                    s_nxt.state = CTL_IDLE;
                end
            end
            CTL_CAPTURE: begin
                s_nxt.ioData = link.periphRdData;
                events[`EV_IO_DONE] = 1'b1;
                s_nxt.state = CTL_IDLE;
            end
            default: s_nxt.state = CTL_IDLE;
        endcase

        s_nxt.nmiPrev = link.nmi;
        events[`EV_NMI] = link.nmi && !s_r.nmiPrev;
        // Set wins over a clear in the same cycle
        s_nxt.status = (s_r.status & ~clearMask) | events;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
            s_r.strobes <= `STROBES_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    always_comb begin
        case (s_r.addrPh)
            `R_STROBES: hrdata = s_r.strobes;
            `R_IO_CMD: hrdata = s_r.cmd;
            `R_IO_DATA: hrdata = {22'h0, link.nmi, s_r.state != CTL_IDLE, s_r.ioData};
            `R_IRQ_STATUS: hrdata = {30'h0, s_r.status};
            `R_IRQ_ENABLE: hrdata = {30'h0, s_r.enable};
            default: hrdata = 32'h0000_0000;
        endcase
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign irq = |(s_r.status & s_r.enable);
    assign link.latchStrobes = s_r.strobes[`ST_LATCH_LSB +: 4];
    assign link.sysDataOutEnableN = s_r.strobes[`ST_SYSTEM_DATA_OUT_ENABLE_N_N];
    assign link.readDirectionN = s_r.strobes[`ST_DIR_N];
    assign link.byteLaneEnablesN = s_r.strobes[`ST_BEN_LSB +: 4];
    assign link.swapGate = s_r.strobes[`ST_SWAP_GATE]; // R3 R6
    assign link.swapDirection = s_r.strobes[`ST_SWAP_DIR]; // R3 R6
    assign link.ioAddr = s_r.cmd[`PORT_ADDR_W-1:0];
    assign link.ioRead = s_r.ioRead;
    assign link.ioWrite = s_r.ioWrite;
    assign link.periphWrData = s_r.cmd[`CMD_DATA_LSB +: 8];
endmodule // buffer_controller

//--- buf_link_properties.sv
// Checker of the link between bus controller and data buffer
`include "buf_cfg.svh"
module buf_link_properties
    import buf_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [15:0] ioAddr,
    input wire logic ioRead,
    input wire logic ioWrite,
    input wire logic [7:0] periphWrData,
    input wire logic [7:0] periphRdData,
    input wire logic nmi
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////////
    // Helper logic
    logic portRd;
    logic portWr;
    logic [3:0] ctlSeen_r;
    assign portRd = ioRead && ioAddr == `PORT_ADDR;
    assign portWr = ioWrite && ioAddr == `PORT_ADDR;
    // Assumes control bits clear at reset
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctlSeen_r <= 4'h0;
        end else if (portWr) begin
            ctlSeen_r <= periphWrData[3:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Properties
    AST_IO_EXCL: assert property (!(ioRead && ioWrite))
        else $error("port read and write strobes overlap");
    AST_RD_PULSE: assert property (ioRead |=> !ioRead)
        else $error("port read strobe longer than one cycle");
    AST_WR_PULSE: assert property (ioWrite |=> !ioWrite)
        else $error("port write strobe longer than one cycle");
    AST_RD_HOLD: assert property (!portRd |=> $stable(periphRdData))
        else $error("port read data changed without a port read");
    AST_RD_BACK: assert property (portRd |=> periphRdData[3:0] == ctlSeen_r)
        else $error("control bits read back differ from last write");
    AST_HIT_NMI: assert property (portRd && !nmi |=> !periphRdData[7])
        else $error("hit status read as set while nmi low");
    AST_NMI_STICKY: assert property (nmi && !portWr |=> nmi)
        else $error("nmi dropped without a port write");
    AST_CMD_STABLE: assert property (
        (ioRead || ioWrite) |-> $stable(ioAddr) && $stable(periphWrData))
        else $error("port address or data moved during strobe");

    cover property (portRd);
    cover property (portWr);
    cover property ($rose(nmi));
endmodule // buf_link_properties

//--- tb_three_width_data_buffer_ctl_port.sv
// Self-checking bench: controller and buffer joined over the link
`include "buf_cfg.svh"
module tb_three_width_data_buffer_ctl_port
    import buf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0, hwrite = 1'b0, hresp, irq, hreadyout;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'b010;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, cpuDataOut, v;
    logic [31:0] cpuDataIn = 32'h0;
    logic [15:0] sysDataIn = 16'h0, sysDataOut;
    logic [3:0] cpuDataOe;
    logic [1:0] sysDataOe;
    logic channelCheckN = 1'b1, parityN = 1'b1, hitTimerInN = 1'b1;
    logic refreshDetect = 1'b0, timer2Out = 1'b0, timer2Gate, speakerEnable;
    logic [7:0] b;
    int fail_count = 0, checks_done = 0, cycles = 0;

    always #25 core_clk = ~core_clk;

    buf_link_if link();
    three_width_data_buffer i_three_width_data_buffer(.core_clk(core_clk), .rst(rst),
        .link(link), .cpuDataIn(cpuDataIn), .cpuDataOut(cpuDataOut), .cpuDataOe(cpuDataOe),
        .sysDataIn(sysDataIn), .sysDataOut(sysDataOut), .sysDataOe(sysDataOe),
        .channelCheckN(channelCheckN), .parityN(parityN), .hitTimerInN(hitTimerInN),
        .refreshDetect(refreshDetect), .timer2Out(timer2Out), .timer2Gate(timer2Gate),
        .speakerEnable(speakerEnable));
    buffer_controller i_buffer_controller(.core_clk(core_clk), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
        .link(link));
    buf_link_properties i_buf_link_properties(.core_clk(core_clk), .rst(rst),
        .ioAddr(link.ioAddr), .ioRead(link.ioRead), .ioWrite(link.ioWrite),
        .periphWrData(link.periphWrData), .periphRdData(link.periphRdData), .nmi(link.nmi));

    ////////////////////////////////////////////////////////////////////////////
    // Tasks
    task automatic test_done();
        $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Ready and read data sampled mid-cycle, so the edge itself never races
    task automatic waitRdy(output logic [31:0] q);
        logic r;
        do begin
            @(negedge core_clk);
            q = hrdata;
            r = hreadyout;
            @(posedge core_clk);
        end while (r !== 1'b1);
    endtask

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'b10;
        waitRdy(q);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        waitRdy(q);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        ahb(1'b1, a, d, q);
    endtask

    // Polls busy; a hang is cut by the cycle ceiling
    task automatic portCyc(input logic rd, input logic [15:0] a, input logic [7:0] d,
        output logic [7:0] q);
        logic [31:0] s;
        wr(`R_IO_CMD, {7'h0, rd, d, a});
        do begin
            ahb(1'b0, `R_IO_DATA, 32'h0, s);
        end while (s[`IOD_BUSY] !== 1'b0);
        q = s[7:0];
    endtask

    task automatic portRead(input logic [7:0] exp);
        logic [7:0] q;
        portCyc(1'b1, `PORT_ADDR, 8'h00, q);
        check(32'(q), 32'(exp));
    endtask

    task automatic setStrobes(input logic sdoeN, input logic dirN, input logic [3:0] latch,
        input logic [3:0] ben, input logic swp);
        wr(`R_STROBES, {18'h0, swp, swp, ben, 2'b00, dirN, sdoeN, latch});
        repeat (3) @(posedge core_clk);
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            test_done();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    initial begin
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        check(32'(hresp), 32'h0);
        ahb(1'b0, `R_STROBES, 32'h0, v);
        check(v, `STROBES_RST);
        ahb(1'b0, 8'h18, 32'h0, v);
        check(v, 32'h0);
        timer2Out <= 1'b1;
        portCyc(1'b0, `PORT_ADDR, 8'h03, b);
        check(32'({timer2Gate, speakerEnable}), 32'h3);
        portRead(8'h23);
        timer2Out <= 1'b0;
        refreshDetect <= 1'b1;
        portCyc(1'b0, `PORT_ADDR, 8'h0C, b);
        check(32'({timer2Gate, speakerEnable}), 32'h0);
        portRead(8'h1C);
        portCyc(1'b1, 16'h0062, 8'h00, b);
        check(32'(b), 32'h1C);
        for (int i = 0; i < 2; i++) begin
            parityN <= (i != 0);
            channelCheckN <= (i == 0);
            repeat (2) @(posedge core_clk);
            parityN <= 1'b1;
            channelCheckN <= 1'b1;
            repeat (3) @(posedge core_clk);
            check(32'(link.nmi), 32'h0);
            portRead(8'h5C);
            portCyc(1'b0, `PORT_ADDR, 8'h80, b);
            check(32'(link.nmi), 32'h1);
            portCyc(1'b0, `PORT_ADDR, 8'h0C, b);
            portRead(8'h1C);
            check(32'(link.nmi), 32'h0);
        end
        wr(`R_IRQ_ENABLE, 32'h3);
        wr(`R_IRQ_CLEAR, 32'h3);
        @(negedge core_clk);
        check(32'(irq), 32'h0);
        @(posedge core_clk);
        hitTimerInN <= 1'b0;
        @(posedge core_clk);
        hitTimerInN <= 1'b1;
        repeat (3) @(posedge core_clk);
        check(32'(link.nmi), 32'h1);
        check(32'(irq), 32'h1);
        ahb(1'b0, `R_IRQ_STATUS, 32'h0, v);
        check(v, 32'h2);
        wr(`R_IRQ_ENABLE, 32'h1);
        @(negedge core_clk);
        check(32'(irq), 32'h0);
        @(posedge core_clk);
        wr(`R_IRQ_CLEAR, 32'h2);
        portRead(8'h9C);
        portCyc(1'b0, `PORT_ADDR, 8'h08, b);
        portRead(8'h18);
        check(32'(link.nmi), 32'h0);
        check(32'(irq), 32'h1);
        wr(`R_IRQ_CLEAR, 32'h1);
        @(negedge core_clk);
        check(32'(irq), 32'h0);
        @(posedge core_clk);
        sysDataIn <= 16'hB7A5;
        setStrobes(1'b1, 1'b1, 4'hF, 4'hF, 1'b0);
        setStrobes(1'b0, 1'b1, 4'h0, 4'hF, 1'b0);
        sysDataIn <= 16'h6E19;
        repeat (2) @(posedge core_clk);
        check(cpuDataOut, 32'hB7A5B7A5);
        check(32'(cpuDataOe), 32'hF);
        setStrobes(1'b1, 1'b0, 4'h0, 4'b1100, 1'b0);
        check(32'({cpuDataOe, cpuDataOut[15:0]}), 32'h36E19);
        cpuDataIn <= 32'h11223344;
        setStrobes(1'b1, 1'b1, 4'h0, 4'b0110, 1'b0);
        check(32'({sysDataOe, sysDataOut}), 32'h31144);
        setStrobes(1'b1, 1'b1, 4'h0, 4'b1101, 1'b1);
        check(32'({sysDataOe, sysDataOut[7:0]}), 32'h133);
        setStrobes(1'b1, 1'b0, 4'h0, 4'b0111, 1'b1);
        check(32'({cpuDataOe, cpuDataOut[31:24]}), 32'h819);
        test_done();
    end
endmodule // tb_three_width_data_buffer_ctl_port
